//--- src/sehc_regs.svh
`ifndef SEHC_REGS_SVH
`define SEHC_REGS_SVH
`define SEHC_CLK_HZ 20000000
`define SEHC_TRIG_MIN_MS 10
`define SEHC_TRIG_CYC ((`SEHC_CLK_HZ / 1000) * `SEHC_TRIG_MIN_MS + 1)
`define SEHC_LED_MS 300
`define SEHC_LED_CYC ((`SEHC_CLK_HZ / 1000) * `SEHC_LED_MS)
`define SEHC_BOOT_MS 200
`define SEHC_BOOT_CYC ((`SEHC_CLK_HZ / 1000) * `SEHC_BOOT_MS)
`define SEHC_BAUD_DEF 9600
`define SEHC_BAUD_MIN 1200
`define SEHC_BAUD_MAX 115200
`define SEHC_BAUD_DIV_DEF (`SEHC_CLK_HZ / `SEHC_BAUD_DEF)
`define SEHC_BEEP_HZ 2700
`define SEHC_BEEP_PER (`SEHC_CLK_HZ / `SEHC_BEEP_HZ)
`define SEHC_BEEP_MS 100
`define SEHC_BEEP_CYC ((`SEHC_CLK_HZ / 1000) * `SEHC_BEEP_MS)
`define SEHC_DATA_BITS 8
`endif

//--- src/sehc_pkg.sv
package sehc_pkg;
   typedef logic [7:0] sehc_byte_t;
   typedef struct packed {
      logic valid;
      sehc_byte_t data;
   } sehc_word_s;
   typedef enum logic [4:0] {
      SEHC_BOOT = 5'b0_0001,
      SEHC_IDLE = 5'b0_0010,
      SEHC_ARM = 5'b0_0100,
      SEHC_SCAN = 5'b0_1000,
      SEHC_HOLD = 5'b1_0000
   } sehc_state_e;
   typedef enum logic [2:0] {
      SEHC_TX_IDLE = 3'b001,
      SEHC_TX_BITS = 3'b010,
      SEHC_TX_STOP = 3'b100
   } sehc_tx_e;
endpackage

//--- src/sehc_buf2.sv
`timescale 1ns/1ps
module sehc_buf2 import sehc_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire sehc_byte_t i_data,
   output logic o_valid,
   input wire logic i_ready,
   output sehc_byte_t o_data
);
   sehc_byte_t mem_q [2];
   sehc_byte_t mem_d [2];
   logic [1:0] cnt_q, cnt_d;
   logic rd_q, rd_d, wr_q, wr_d;
   logic push, pop;
   assign o_ready = (cnt_q != 2'd2);
   assign o_valid = (cnt_q != 2'd0);
   assign o_data = mem_q[rd_q];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = i_data;
         wr_d = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'd1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'd1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_q[0] <= 8'h00;
         mem_q[1] <= 8'h00;
         cnt_q <= 2'd0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         mem_q <= mem_d;
         cnt_q <= cnt_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
      end
   end
   a_buf_no_over: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cnt_q == 2'd2 |-> !o_ready)
      else $error("buffer accepts when full");
endmodule // sehc_buf2

//--- src/sehc_top.sv
`timescale 1ns/1ps
`include "sehc_regs.svh"
// Overview of operation
// - session starts after trigger low over 10ms
// - after decode send data, wait release
// - trigger release before decode aborts running scan immediately
// - next session needs fresh trigger low
// - baud 1200 to 115200, no flow control
// - reset framing 9600 baud, 8N1
// - transmit on tx line, receive rx
// - good read drives indicator ~300ms high
// - beeper carries PWM on status events
// - ready within 200ms after power
module sehc_top import sehc_pkg::*; #(
   // time counts open for override, defaults are the device figures
   parameter int TRIG_CYC = `SEHC_TRIG_CYC,
   parameter int LED_CYC = `SEHC_LED_CYC,
   parameter int BOOT_CYC = `SEHC_BOOT_CYC,
   parameter int BEEP_CYC = `SEHC_BEEP_CYC,
   parameter int BEEP_PER = `SEHC_BEEP_PER
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_scan_trigger_n,
   input wire logic i_rx,
   input wire logic i_decode_done,
   input wire logic i_dec_valid,
   input wire sehc_byte_t i_dec_data,
   input wire logic i_dec_last,
   input wire logic [15:0] i_baud_div,
   output logic o_dec_ready,
   output logic o_tx,
   output logic o_good_read,
   output logic o_beep,
   output logic o_scan_active,
   output logic o_scan_abort,
   output logic o_ready,
   output logic o_rx_valid,
   output sehc_byte_t o_rx_data
);
   localparam logic [15:0] DIV_DEF = 16'(`SEHC_BAUD_DIV_DEF);
   localparam logic [15:0] DIV_MIN = 16'(`SEHC_CLK_HZ / `SEHC_BAUD_MAX);
   localparam logic [15:0] DIV_MAX = 16'(`SEHC_CLK_HZ / `SEHC_BAUD_MIN);

   logic rs1_q, rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end

   // session control
   sehc_state_e st_q, st_d;
   logic [22:0] cnt_q, cnt_d;
   logic act_q, act_d, abt_q, abt_d, rdy_q, rdy_d, sent_q, sent_d;
   logic good_evt, boot_evt;
   logic buf_in_ready, buf_valid, buf_pop, tx_idle;
   logic trig_low;
   assign trig_low = !i_scan_trigger_n;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      act_d = 1'b0;
      abt_d = 1'b0;
      rdy_d = rdy_q;
      sent_d = sent_q;
      good_evt = 1'b0;
      boot_evt = 1'b0;
      case (st_q)
         SEHC_BOOT: begin
            cnt_d = cnt_q + 23'd1;
            if (cnt_q == 23'(BOOT_CYC - 1)) begin
               rdy_d = 1'b1;
               boot_evt = 1'b1;
               cnt_d = '0;
               st_d = trig_low ? SEHC_HOLD : SEHC_IDLE;
            end
         end
         SEHC_IDLE: begin
            cnt_d = '0;
            if (trig_low) begin
               st_d = SEHC_ARM;
               cnt_d = 23'd1;
            end
         end
         SEHC_ARM: begin
            if (!trig_low) begin
               st_d = SEHC_IDLE;
               cnt_d = '0;
            end else if (cnt_q >= 23'(TRIG_CYC - 1)) begin
               st_d = SEHC_SCAN;
               act_d = 1'b1;
               sent_d = 1'b0;
            end else begin
               cnt_d = cnt_q + 23'd1;
            end
         end
         SEHC_SCAN: begin
            act_d = 1'b1;
            if (!trig_low && !sent_q) begin
               act_d = 1'b0;
               abt_d = 1'b1;
               st_d = SEHC_IDLE;
            end else if (i_decode_done) begin
               sent_d = 1'b1;
               good_evt = !sent_q;
            end
            if (sent_q && !buf_valid && tx_idle) begin
               act_d = 1'b0;
               st_d = trig_low ? SEHC_HOLD : SEHC_IDLE;
            end
         end
         SEHC_HOLD: begin
            if (!trig_low) begin
               st_d = SEHC_IDLE;
            end
         end
         default: st_d = SEHC_BOOT;
      endcase
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= SEHC_BOOT;
         cnt_q <= '0;
         act_q <= 1'b0;
         abt_q <= 1'b0;
         rdy_q <= 1'b0;
         sent_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         act_q <= act_d;
         abt_q <= abt_d;
         rdy_q <= rdy_d;
         sent_q <= sent_d;
      end
   end
   assign o_scan_active = act_q;
   assign o_scan_abort = abt_q;
   assign o_ready = rdy_q;

   // decoded data path; buffer absorbs tx stalls
   sehc_byte_t buf_data;
   logic dec_ready_q, buf_push, buf_full_nxt;
   assign buf_push = i_dec_valid && dec_ready_q;
   // ready is registered, so it must look one edge ahead at the fill level
   assign buf_full_nxt = (!buf_in_ready && !buf_pop)
      || (buf_in_ready && buf_valid && buf_push && !buf_pop);
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_ready_q <= 1'b0;
      end else begin
         dec_ready_q <= !buf_full_nxt && (st_d == SEHC_SCAN);
      end
   end
   assign o_dec_ready = dec_ready_q;
   sehc_buf2 u_buf (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_valid(buf_push),
      .o_ready(buf_in_ready),
      .i_data(i_dec_data),
      .o_valid(buf_valid),
      .i_ready(buf_pop),
      .o_data(buf_data)
   );

   // serial transmitter, no flow control lines by design
   sehc_tx_e tx_q, tx_d;
   logic [15:0] div_q, div_d, bdiv_q, bdiv_d, bcnt_q, bcnt_d;
   logic [8:0] sh_q, sh_d;
   logic [3:0] nb_q, nb_d;
   logic tx_o_q, tx_o_d;
   assign tx_idle = (tx_q == SEHC_TX_IDLE);
   assign buf_pop = tx_idle && buf_valid;
   always_comb begin
      div_d = div_q;
      // out-of-range requests keep the last legal rate
      if (i_baud_div >= DIV_MIN && i_baud_div <= DIV_MAX) begin
         div_d = i_baud_div;
      end
      tx_d = tx_q;
      bdiv_d = bdiv_q;
      bcnt_d = bcnt_q;
      sh_d = sh_q;
      nb_d = nb_q;
      tx_o_d = tx_o_q;
      case (tx_q)
         SEHC_TX_IDLE: begin
            tx_o_d = 1'b1;
            if (buf_valid) begin
               sh_d = {1'b1, buf_data};
               bdiv_d = div_q;
               bcnt_d = '0;
               nb_d = '0;
               tx_o_d = 1'b0;
               tx_d = SEHC_TX_BITS;
            end
         end
         SEHC_TX_BITS: begin
            bcnt_d = bcnt_q + 16'd1;
            if (bcnt_q == bdiv_q - 16'd1) begin
               bcnt_d = '0;
               tx_o_d = sh_q[0];
               sh_d = {1'b1, sh_q[8:1]};
               nb_d = nb_q + 4'd1;
               if (nb_q == 4'(`SEHC_DATA_BITS)) begin
                  tx_d = SEHC_TX_STOP;
               end
            end
         end
         SEHC_TX_STOP: begin
            bcnt_d = bcnt_q + 16'd1;
            if (bcnt_q == bdiv_q - 16'd1) begin
               tx_d = SEHC_TX_IDLE;
            end
         end
         default: tx_d = SEHC_TX_IDLE;
      endcase
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= SEHC_TX_IDLE;
         div_q <= DIV_DEF;
         bdiv_q <= DIV_DEF;
         bcnt_q <= '0;
         sh_q <= '1;
         nb_q <= '0;
         tx_o_q <= 1'b1;
      end else begin
         tx_q <= tx_d;
         div_q <= div_d;
         bdiv_q <= bdiv_d;
         bcnt_q <= bcnt_d;
         sh_q <= sh_d;
         nb_q <= nb_d;
         tx_o_q <= tx_o_d;
      end
   end
   assign o_tx = tx_o_q;

   // serial receiver: mid-bit sampling
   logic [1:0] rsy_q;
   logic [15:0] rcnt_q, rcnt_d;
   logic [3:0] rnb_q, rnb_d;
   logic [7:0] rsh_q, rsh_d;
   logic rbusy_q, rbusy_d, rv_q, rv_d;
   sehc_byte_t rdat_q, rdat_d;
   always_comb begin
      rcnt_d = rcnt_q;
      rnb_d = rnb_q;
      rsh_d = rsh_q;
      rbusy_d = rbusy_q;
      rv_d = 1'b0;
      rdat_d = rdat_q;
      if (!rbusy_q) begin
         if (!rsy_q[1]) begin
            rbusy_d = 1'b1;
            rcnt_d = {1'b0, div_q[15:1]};
            rnb_d = '0;
         end
      end else if (rcnt_q == 16'd0) begin
         rcnt_d = div_q - 16'd1;
         rnb_d = rnb_q + 4'd1;
         if (rnb_q == 4'd0 && rsy_q[1]) begin
            rbusy_d = 1'b0; // false start
         end else if (rnb_q == 4'(`SEHC_DATA_BITS + 1)) begin
            rbusy_d = 1'b0;
            rv_d = rsy_q[1];
            rdat_d = rsy_q[1] ? rsh_q : rdat_q;
         end else if (rnb_q != 4'd0) begin
            rsh_d = {rsy_q[1], rsh_q[7:1]};
         end
      end else begin
         rcnt_d = rcnt_q - 16'd1;
      end
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsy_q <= 2'b11;
         rcnt_q <= '0;
         rnb_q <= '0;
         rsh_q <= '0;
         rbusy_q <= 1'b0;
         rv_q <= 1'b0;
         rdat_q <= '0;
      end else begin
         rsy_q <= {rsy_q[0], i_rx};
         rcnt_q <= rcnt_d;
         rnb_q <= rnb_d;
         rsh_q <= rsh_d;
         rbusy_q <= rbusy_d;
         rv_q <= rv_d;
         rdat_q <= rdat_d;
      end
   end
   assign o_rx_valid = rv_q;
   assign o_rx_data = rdat_q;

   // indicators
   logic [22:0] led_q, led_d;
   logic [21:0] bp_q, bp_d;
   logic [15:0] pw_q, pw_d;
   logic gr_q, gr_d, bz_q, bz_d;
   always_comb begin
      led_d = led_q;
      gr_d = 1'b0;
      if (good_evt) begin
         led_d = 23'(LED_CYC);
      end else if (led_q != '0) begin
         led_d = led_q - 23'd1;
      end
      gr_d = (led_d != '0);
      bp_d = bp_q;
      pw_d = pw_q;
      if (good_evt || boot_evt) begin
         bp_d = 22'(BEEP_CYC);
      end else if (bp_q != '0) begin
         bp_d = bp_q - 22'd1;
      end
      pw_d = (pw_q == 16'(BEEP_PER - 1)) ? 16'd0 : pw_q + 16'd1;
      // 50% duty square; external driver sets loudness
      bz_d = (bp_d != '0) && (pw_d < 16'(BEEP_PER / 2));
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         led_q <= '0;
         bp_q <= '0;
         pw_q <= '0;
         gr_q <= 1'b0;
         bz_q <= 1'b0;
      end else begin
         led_q <= led_d;
         bp_q <= bp_d;
         pw_q <= pw_d;
         gr_q <= gr_d;
         bz_q <= bz_d;
      end
   end
   assign o_good_read = gr_q;
   assign o_beep = bz_q;

   a_short_low_ignored: assert property (@(posedge i_clk) disable iff (!rst_n)
      (st_q == SEHC_ARM && !trig_low) |=> !act_q)
      else $error("short trigger started session");
   a_release_aborts: assert property (@(posedge i_clk) disable iff (!rst_n)
      (st_q == SEHC_SCAN && !trig_low && !sent_q) |=> (abt_q && !act_q))
      else $error("release did not abort");
   a_hold_no_scan: assert property (@(posedge i_clk) disable iff (!rst_n)
      (st_q == SEHC_HOLD) |=> !act_q)
      else $error("session without fresh trigger");
   a_led_on_read: assert property (@(posedge i_clk) disable iff (!rst_n)
      good_evt |=> gr_q [*8])
      else $error("good read indicator not held");
   a_tx_start_bit: assert property (@(posedge i_clk) disable iff (!rst_n)
      (tx_q == SEHC_TX_IDLE && buf_valid) |=> !o_tx)
      else $error("missing start bit");
   a_tx_idle_high: assert property (@(posedge i_clk) disable iff (!rst_n)
      (tx_q == SEHC_TX_STOP) |-> o_tx)
      else $error("stop bit not high");
   a_boot_ready: assert property (@(posedge i_clk) disable iff (!rst_n)
      (st_q != SEHC_BOOT) |-> rdy_q)
      else $error("left boot without ready");
   a_beep_gated: assert property (@(posedge i_clk) disable iff (!rst_n)
      (bp_q == '0) |-> !bz_q)
      else $error("beeper active without event");
   a_div_legal: assert property (@(posedge i_clk) disable iff (!rst_n)
      (div_q >= DIV_MIN && div_q <= DIV_MAX))
      else $error("baud outside range");
   a_ready_has_room: assert property (@(posedge i_clk) disable iff (!rst_n)
      dec_ready_q |-> buf_in_ready)
      else $error("byte offered without buffer room");
endmodule // sehc_top

//--- tb/sehc_host_model.sv
`timescale 1ns/1ps
module sehc_host_model #(
   parameter int GAP_CYC = 1000001
) (
   input wire logic i_clk,
   input wire logic i_tx,
   output logic o_rx,
   output logic o_trig_n
);
   initial begin
      o_rx = 1'b1;
      o_trig_n = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask
   task automatic set_trig(input logic v);
      o_trig_n = v;
   endtask
   // quiet time between activations, a capture must finish first
   task automatic gap();
      cyc(GAP_CYC);
   endtask
   // line idles high once the stop bit is out
   task automatic send_byte(input int div, input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rx = f[i];
         cyc(div);
      end
   endtask
   // no flow control: only listens, never throttles the sender
   task automatic recv_byte(input int div, output logic [7:0] b, output logic ok);
      int n;
      logic st;
      n = 0;
      b = 8'h00;
      while (i_tx !== 1'b0 && n < 40000) begin
         @(posedge i_clk);
         n++;
      end
      repeat (div / 2) @(posedge i_clk);
      st = i_tx;
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge i_clk);
         b[i] = i_tx;
      end
      repeat (div) @(posedge i_clk);
      ok = (st === 1'b0) && (i_tx === 1'b1) && (n < 40000);
   endtask
endmodule // sehc_host_model

//--- tb/sehc_top_tb_top.sv
`timescale 1ns/1ps
module sehc_top_tb_top;
   // time counts shortened to keep the run short; their ratios follow the rules, except BPER
   localparam int TRIG = 201;
   localparam int LED = 6000;
   localparam int BOOT = 4000;
   localparam int BEEP = 2000;
   localparam int BPER = 40;
   localparam int DIV_DEF = 2083;
   localparam int DIV_FAST = 173;
   logic clk, arst_n, trig_n, rx, decode_done, dec_valid, dec_last;
   logic dec_ready, tx, good_read, beep, scan_active, scan_abort, ready, rx_valid;
   logic [15:0] baud_div;
   sehc_pkg::sehc_byte_t dec_data, rx_data;
   int error_cnt = 0;
   int compares = 0;

   sehc_top #(.TRIG_CYC(TRIG), .LED_CYC(LED), .BOOT_CYC(BOOT), .BEEP_CYC(BEEP),
      .BEEP_PER(BPER)) dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_scan_trigger_n(trig_n),
      .i_rx(rx), .i_decode_done(decode_done), .i_dec_valid(dec_valid), .i_dec_data(dec_data),
      .i_dec_last(dec_last), .i_baud_div(baud_div), .o_dec_ready(dec_ready), .o_tx(tx),
      .o_good_read(good_read), .o_beep(beep), .o_scan_active(scan_active),
      .o_scan_abort(scan_abort), .o_ready(ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
   sehc_host_model #(.GAP_CYC(5 * (TRIG - 1) + 1)) host_u (.i_clk(clk), .i_tx(tx), .o_rx(rx),
      .o_trig_n(trig_n));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic print_verdict();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input int got);
      compares++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return ready;
         1: return scan_active;
         2: return scan_abort;
         3: return good_read;
         default: return rx_valid;
      endcase
   endfunction
   // bounded wait; running out of the bound ends the run
   task automatic wait_for(input int k, input int lim, output int n);
      n = 0;
      while (pick(k) !== 1'b1) begin
         if (n >= lim) begin
            chk("wait bound", 0, 1);
            print_verdict();
         end
         @(posedge clk);
         #5;
         n++;
      end
   endtask
   task automatic start_session();
      int n;
      host_u.set_trig(1'b0);
      wait_for(1, TRIG + 100, n);
      rng("trigger low cycles", TRIG, TRIG + 3, n);
   endtask
   task automatic pulse_done();
      decode_done = 1'b1;
      host_u.cyc(1);
      decode_done = 1'b0;
   endtask
   // offers one byte and holds it up to the edge where ready is seen high
   task automatic feed(input logic [7:0] b, input logic last);
      int n;
      dec_data = b;
      dec_last = last;
      dec_valid = 1'b1;
      n = 0;
      while (dec_ready !== 1'b1 && n < 50) begin
         host_u.cyc(1);
         n++;
      end
      chk("byte taken", 1, dec_ready);
      host_u.cyc(1);
   endtask
   task automatic count_beep(output int t);
      logic last;
      t = 0;
      last = beep;
      repeat (BEEP + BEEP / 4) begin
         host_u.cyc(1);
         if (beep !== last) t++;
         last = beep;
      end
   endtask

   task automatic t_boot();
      int n;
      chk("tx at reset", 1, tx);
      chk("ready at reset", 0, ready);
      wait_for(0, BOOT + 100, n);
      rng("start-up cycles", BOOT, BOOT + 4, n);
      count_beep(n);
      rng("beep edges after start-up", 2 * BEEP / BPER - 3, 2 * BEEP / BPER + 3, n);
   endtask

   task automatic t_glitch_abort();
      int n;
      host_u.set_trig(1'b0);
      host_u.cyc(TRIG - 1);
      host_u.set_trig(1'b1);
      host_u.cyc(4);
      chk("active after short low", 0, scan_active);
      host_u.gap();
      start_session();
      host_u.set_trig(1'b1);
      wait_for(2, 4, n);
      rng("abort delay", 0, 3, n);
      host_u.cyc(1);
      chk("abort width", 0, scan_abort);
      chk("active after abort", 0, scan_active);
      chk("ready to take bytes", 0, dec_ready);
      host_u.gap();
   endtask

   task automatic t_decode();
      logic [7:0] pat [3] = '{8'hA5, 8'h01, 8'h80};
      logic [7:0] got [3];
      logic ok [3];
      int led, bt;
      start_session();
      for (int i = 0; i < 3; i++) feed(pat[i], i == 2);
      dec_valid = 1'b0;
      dec_last = 1'b0;
      pulse_done();
      chk("active while sending", 1, scan_active);
      fork
         for (int i = 0; i < 3; i++) host_u.recv_byte(DIV_DEF, got[i], ok[i]);
         begin
            led = 0;
            while (good_read === 1'b1 && led < 2 * LED) begin
               host_u.cyc(1);
               led++;
            end
         end
         count_beep(bt);
      join
      for (int i = 0; i < 3; i++) begin
         chk("tx byte", pat[i], got[i]);
         chk("tx framing", 1, ok[i]);
      end
      rng("good read cycles", LED - 3, LED + 2, led);
      rng("beep edges after decode", 2 * BEEP / BPER - 3, 2 * BEEP / BPER + 3, bt);
      host_u.cyc(DIV_DEF);
      chk("active after send, trigger held", 0, scan_active);
      chk("ready after session", 0, dec_ready);
      host_u.cyc(TRIG + 2);
      chk("no session while trigger held", 0, scan_active);
      host_u.set_trig(1'b1);
      host_u.gap();
   endtask

   task automatic t_fast_baud();
      logic [7:0] b;
      logic ok;
      int n;
      baud_div = 16'h00AD;
      host_u.cyc(2);
      baud_div = 16'h0064;
      start_session();
      chk("new session after fresh low", 1, scan_active);
      feed(8'h3C, 1'b1);
      dec_valid = 1'b0;
      dec_last = 1'b0;
      pulse_done();
      fork
         host_u.recv_byte(DIV_FAST, b, ok);
         host_u.send_byte(DIV_FAST, 8'hC3);
         begin
            wait_for(4, 3000, n);
            chk("rx byte", 8'hC3, rx_data);
         end
      join
      chk("tx byte fast", 8'h3C, b);
      chk("tx framing fast", 1, ok);
      host_u.set_trig(1'b1);
   endtask

   initial begin
      arst_n = 1'b0;
      decode_done = 1'b0;
      dec_valid = 1'b0;
      dec_last = 1'b0;
      dec_data = 8'h00;
      baud_div = 16'h0823;
      repeat (2) @(posedge clk);
      #5;
      arst_n = 1'b1;
      t_boot();
      t_glitch_abort();
      t_decode();
      t_fast_baud();
      print_verdict();
   end
endmodule // sehc_top_tb_top
